// ==== core/adc_seq_pkg.sv ====
// constants, register map and carrier types for the conversion sequencer
// Behaviour
// R1: trigger starts conversion only with compare mode 1011b and power-on set
// R2: accepted trigger sets run flag at second quarter phase and clears timer
// R3: with power off the trigger is ignored but still clears the timer
// R4: software selects the channel before any start
// R5: reset restores control registers, powers down and aborts conversion
// R6: reset leaves result registers untouched
// R7: clearing run flag early halts; unconverted bits read zero
// R8: software times an early halt itself, N plus one bit periods
// R9: conversion survives sleep only with clock select 11
// R10: with RC clock, one instruction cycle delay before conversion starts; the code waits 1 to 4 system clocks, up to quarter 3
// R11: at completion run flag clears and results load
// R12: done in sleep wakes if enabled, else converter powers down, power bit kept
// R13: non-RC clock: sleep aborts conversion and powers down, power bit kept
// R14: conversion is one settling period then twelve bit periods
// R15: done flag rises at fourteenth period start, run flag clears at its end; the code clears run one system clock after done rises
// R16: clock select gives 2, 8, 32 oscillator periods or RC
// R17: clearing run flag mid-conversion loads the partial value
// R18: software setting run flag starts like an accepted trigger
// R19: done flag sticky until cleared, raises interrupt when enabled
`default_nettype none
package adc_seq_pkg;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0b;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0c;
  localparam logic [7:0] ADDR_RESH   = 8'h1e;
  localparam logic [7:0] ADDR_CTRL0  = 8'h1f;
  localparam logic [7:0] ADDR_ENAB   = 8'h8c;
  localparam logic [7:0] ADDR_REFC   = 8'h9b;
  localparam logic [7:0] ADDR_RESL   = 8'h9e;
  localparam logic [7:0] ADDR_CFG1   = 8'h9f;
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  // control 0 fields
  localparam int BIT_POWER = 0;
  localparam int BIT_RUN   = 2;
  localparam int BIT_CLK_LO = 6;
  localparam int CLK_WIDTH  = 2;
  localparam int BIT_CHAN_HI = 1;
  localparam int BIT_CHAN_LO = 3;
  localparam int CHAN_LO_WIDTH = 3;
  // interrupt control, flag and enable positions
  localparam int BIT_GLOBAL_IE = 7;
  localparam int BIT_PERIPH_IE = 6;
  localparam int BIT_DONE      = 6;
  localparam logic [7:0] REFC_MASK = 8'hf0;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;
  localparam logic [1:0] CLK_DIV2  = 2'h0;
  localparam logic [1:0] CLK_DIV8  = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC = 2'h3;
  localparam logic [5:0] DIV_2  = 6'h02;
  localparam logic [5:0] DIV_8  = 6'h08;
  localparam logic [5:0] DIV_32 = 6'h20;
  localparam logic [3:0] SETTLE_PERIODS = 4'h1;
  localparam logic [3:0] RESULT_BITS    = 4'hc;
  localparam logic [3:0] LAST_PERIOD    = 4'hd;
  localparam logic [1:0] SECOND_QUARTER = 2'h1;
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DELAY  = 3'b001,
    ST_CONV   = 3'b010,
    ST_FINISH = 3'b011
  } seq_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;
endpackage : adc_seq_pkg
`default_nettype wire

// ==== core/adc_conversion_sequencer.sv ====
// conversion sequencer: registers, bit period timing, run/done flags, sleep handling
`default_nettype none
module adc_conversion_sequencer #(
  parameter int RC_DIV = 16
) (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_n_in,
  input  wire adc_seq_pkg::bus_req_s   bus_in,
  output logic [7:0]                   rdata_out,
  input  wire logic [3:0]              compare_mode_in,
  input  wire logic                    special_trigger_in,
  input  wire logic                    sleep_in,
  input  wire logic                    comparator_in,
  output logic                         timer_clear_out,
  output logic                         wake_out,
  output logic                         irq_out,
  output logic                         converter_enabled_out,
  output logic                         sampling_out,
  output logic [3:0]                   channel_out
);
  // control 0 fields, split so each can be read back in its place
  logic [1:0]              clk_sel_reg;
  logic [1:0]              clk_sel_next;
  logic [3:0]              chan_reg;
  logic [3:0]              chan_next;
  logic                    power_reg;
  logic                    power_next;

  // plain storage registers around the converter
  logic [7:0]              irq_ctrl_reg;
  logic [7:0]              irq_ctrl_next;
  logic [7:0]              enables_reg;
  logic [7:0]              enables_next;
  logic [7:0]              ref_reg;
  logic [7:0]              ref_next;
  logic [7:0]              cfg1_reg;
  logic [7:0]              cfg1_next;

  // sticky conversion done flag
  logic                    done_reg;
  logic                    done_next;

  // sequencing state and timing
  adc_seq_pkg::seq_state_e state_reg;
  adc_seq_pkg::seq_state_e state_next;
  logic [1:0]              quarter_reg;
  logic [1:0]              quarter_next;
  logic [5:0]              div_reg;
  logic [5:0]              div_next;
  logic [3:0]              period_reg;
  logic [3:0]              period_next;

  // successive approximation word and the result it lands in
  logic [11:0]             sar_reg;
  logic [11:0]             sar_next;
  logic [11:0]             result_reg;

  // trigger, sleep and bus side state
  logic                    trig_pending_reg;
  logic                    trig_pending_next;
  logic                    off_reg;
  logic                    off_next;
  logic                    wake_reg;
  logic                    wake_next;
  logic                    timer_clear_reg;
  logic [7:0]              rdata_reg;
  logic [7:0]              rdata_next;

  // bus strobes, one per writable register
  logic                    wr_irq_ctrl;
  logic                    wr_flags;
  logic                    wr_ctrl0;
  logic                    wr_enables;
  logic                    wr_refc;
  logic                    wr_cfg1;

  // sequencing events
  logic                    run_flag;
  logic                    use_rc;
  logic                    trig_seen;
  logic                    trig_accept;
  logic                    sw_start;
  logic                    hw_start;
  logic                    start_go;
  logic                    sw_abort;
  logic                    sleep_abort;
  logic                    abort_any;
  logic [5:0]              divisor;
  logic                    bit_tick;
  logic                    final_tick;
  logic                    resolve_tick;
  logic                    load_result;
  logic                    done_clear;

  // read side
  logic [7:0]              ctrl_read;
  logic [7:0]              flags_read;
  logic [7:0]              read_mux;

  // bit period length in system clocks for a clock select code
  // the rc source is modelled as a fixed divide, it has no clock of its own
  function automatic logic [5:0] clk_divisor(input logic [1:0] sel);
    logic [5:0] len;
    len = 6'(RC_DIV);
    case (sel)
      adc_seq_pkg::CLK_DIV2:
      begin
        len = adc_seq_pkg::DIV_2;
      end
      adc_seq_pkg::CLK_DIV8:
      begin
        len = adc_seq_pkg::DIV_8;
      end
      adc_seq_pkg::CLK_DIV32:
      begin
        len = adc_seq_pkg::DIV_32;
      end
      default:
      begin
        len = 6'(RC_DIV);
      end
    endcase
    return len;
  endfunction : clk_divisor

  // result bit resolved at the end of a given conversion period
  function automatic logic [3:0] bit_index(input logic [3:0] period);
    return adc_seq_pkg::RESULT_BITS - period;
  endfunction : bit_index

  // register write decode
  assign wr_irq_ctrl = bus_in.wr && (bus_in.addr == adc_seq_pkg::ADDR_IRQ_CTRL);
  assign wr_flags    = bus_in.wr && (bus_in.addr == adc_seq_pkg::ADDR_FLAGS);
  assign wr_ctrl0    = bus_in.wr && (bus_in.addr == adc_seq_pkg::ADDR_CTRL0);
  assign wr_enables  = bus_in.wr && (bus_in.addr == adc_seq_pkg::ADDR_ENAB);
  assign wr_refc     = bus_in.wr && (bus_in.addr == adc_seq_pkg::ADDR_REFC);
  assign wr_cfg1     = bus_in.wr && (bus_in.addr == adc_seq_pkg::ADDR_CFG1);

  // trigger qualification: only the special event mode counts
  assign run_flag    = (state_reg != adc_seq_pkg::ST_IDLE);
  assign use_rc      = (clk_sel_reg == adc_seq_pkg::CLK_RC);
  assign trig_seen   = special_trigger_in
                       && (compare_mode_in == adc_seq_pkg::MODE_SPECIAL); // R3
  assign trig_accept = trig_seen && power_reg && !off_reg && !run_flag; // R1

  // starts: old power bit must already be set, so power and go together is refused
  assign sw_start    = wr_ctrl0
                       && bus_in.wdata[adc_seq_pkg::BIT_RUN]
                       && bus_in.wdata[adc_seq_pkg::BIT_POWER]
                       && power_reg; // R18
  assign hw_start    = trig_pending_reg
                       && (quarter_reg == adc_seq_pkg::SECOND_QUARTER); // R2
  assign start_go    = (sw_start || hw_start) && !run_flag && !off_reg;

  // aborts: software dropping go or power, or sleep on a non-rc clock
  assign sw_abort    = run_flag && wr_ctrl0
                       && !(bus_in.wdata[adc_seq_pkg::BIT_RUN]
                            && bus_in.wdata[adc_seq_pkg::BIT_POWER]); // R17
  assign sleep_abort = run_flag && sleep_in && !use_rc; // R13
  assign abort_any   = sw_abort || sleep_abort;

  // bit period enable pulse and the period counter around it
  assign divisor      = clk_divisor(clk_sel_reg); // R16
  assign bit_tick     = (state_reg == adc_seq_pkg::ST_CONV)
                        && (div_reg == (divisor - 6'h01));
  assign final_tick   = bit_tick && (period_reg == adc_seq_pkg::RESULT_BITS); // R14
  assign resolve_tick = bit_tick && (period_reg >= adc_seq_pkg::SETTLE_PERIODS); // R14

  // results move on completion and on a software abort, never on a sleep abort
  assign load_result = (state_reg == adc_seq_pkg::ST_FINISH) || sw_abort; // R11 R17
  assign done_clear  = wr_flags && bus_in.wdata[adc_seq_pkg::BIT_DONE];

  // read back images
  assign ctrl_read  = {clk_sel_reg, chan_reg[2:0], run_flag, chan_reg[3], power_reg};
  assign flags_read = 8'(done_reg) << adc_seq_pkg::BIT_DONE;

  // read mux, unknown addresses read as zero
  always_comb
  begin
    read_mux = adc_seq_pkg::RESET_BYTE;
    case (bus_in.addr)
      adc_seq_pkg::ADDR_IRQ_CTRL: read_mux = irq_ctrl_reg;
      adc_seq_pkg::ADDR_FLAGS:    read_mux = flags_read;
      adc_seq_pkg::ADDR_RESH:     read_mux = result_reg[11:4];
      adc_seq_pkg::ADDR_CTRL0:    read_mux = ctrl_read;
      adc_seq_pkg::ADDR_ENAB:     read_mux = enables_reg;
      adc_seq_pkg::ADDR_REFC:     read_mux = ref_reg;
      adc_seq_pkg::ADDR_RESL:     read_mux = {result_reg[3:0], 4'h0};
      adc_seq_pkg::ADDR_CFG1:     read_mux = cfg1_reg;
      default:                    read_mux = adc_seq_pkg::RESET_BYTE;
    endcase
  end

  // register next values; sleep never touches the power bit
  assign clk_sel_next  = wr_ctrl0
                         ? bus_in.wdata[adc_seq_pkg::BIT_CLK_LO +: adc_seq_pkg::CLK_WIDTH]
                         : clk_sel_reg;
  assign chan_next     = wr_ctrl0
                         ? {bus_in.wdata[adc_seq_pkg::BIT_CHAN_HI],
                            bus_in.wdata[adc_seq_pkg::BIT_CHAN_LO +: adc_seq_pkg::CHAN_LO_WIDTH]}
                         : chan_reg;
  assign power_next    = wr_ctrl0 ? bus_in.wdata[adc_seq_pkg::BIT_POWER] : power_reg; // R12 R13
  assign irq_ctrl_next = wr_irq_ctrl ? bus_in.wdata : irq_ctrl_reg;
  assign enables_next  = wr_enables ? bus_in.wdata : enables_reg;
  assign ref_next      = wr_refc ? (bus_in.wdata & adc_seq_pkg::REFC_MASK) : ref_reg;
  assign cfg1_next     = wr_cfg1 ? bus_in.wdata : cfg1_reg;

  // set wins over a clear in the same cycle, so no completion is lost
  assign done_next = final_tick || (done_reg && !done_clear); // R15 R19

  // timing counters
  assign quarter_next = quarter_reg + 2'h1;
  assign div_next     = ((state_reg != adc_seq_pkg::ST_CONV) || bit_tick)
                        ? 6'h00
                        : div_reg + 6'h01;
  assign period_next  = (state_reg != adc_seq_pkg::ST_CONV)
                        ? 4'h0
                        : (bit_tick ? period_reg + 4'h1 : period_reg);

  // a trigger waits for the second quarter of the instruction cycle
  assign trig_pending_next = trig_accept || (trig_pending_reg && !hw_start); // R2

  // converter off in sleep: any non-rc clock, or rc done with no wake enabled
  assign off_next  = sleep_in
                     && (!use_rc || off_reg
                         || (final_tick && !enables_reg[adc_seq_pkg::BIT_DONE])); // R9 R12 R13
  assign wake_next = final_tick && sleep_in && enables_reg[adc_seq_pkg::BIT_DONE]; // R12

  // read data stand only in the cycle after the strobe
  assign rdata_next = bus_in.rd ? read_mux : adc_seq_pkg::RESET_BYTE;

  // sequencer: idle, rc start delay, conversion, one finishing cycle
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      adc_seq_pkg::ST_IDLE:
      begin
        if (start_go)
        begin
          state_next = use_rc ? adc_seq_pkg::ST_DELAY : adc_seq_pkg::ST_CONV;
        end
      end
      adc_seq_pkg::ST_DELAY:
      begin
        // delay to the last quarter of the instruction cycle so a sleep can start before the noise does
        if (quarter_reg == adc_seq_pkg::QUARTER_LAST)
        begin
          state_next = adc_seq_pkg::ST_CONV; // R10
        end
      end
      adc_seq_pkg::ST_CONV:
      begin
        if (final_tick)
        begin
          state_next = adc_seq_pkg::ST_FINISH; // R15
        end
      end
      adc_seq_pkg::ST_FINISH:
      begin
        state_next = adc_seq_pkg::ST_IDLE; // R11
      end
      default:
      begin
        state_next = adc_seq_pkg::ST_IDLE;
      end
    endcase
    if (abort_any)
    begin
      state_next = adc_seq_pkg::ST_IDLE; // R13 R17
    end
  end

  // approximation word: cleared at start so unconverted bits stay zero
  always_comb
  begin
    sar_next = sar_reg;
    if (start_go)
    begin
      sar_next = '0; // R7
    end
    else if (resolve_tick)
    begin
      sar_next[bit_index(period_reg)] = comparator_in; // R14
    end
  end

  // control 0 fields
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      clk_sel_reg <= 2'h0; // R5
      chan_reg    <= 4'h0;
      power_reg   <= 1'b0;
    end
    else
    begin
      clk_sel_reg <= clk_sel_next;
      chan_reg    <= chan_next;
      power_reg   <= power_next;
    end
  end

  // interrupt control and enables
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_ctrl_reg <= adc_seq_pkg::RESET_BYTE; // R5
      enables_reg  <= adc_seq_pkg::RESET_BYTE;
    end
    else
    begin
      irq_ctrl_reg <= irq_ctrl_next;
      enables_reg  <= enables_next;
    end
  end

  // reference and configuration storage
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ref_reg  <= adc_seq_pkg::RESET_BYTE; // R5
      cfg1_reg <= adc_seq_pkg::RESET_BYTE;
    end
    else
    begin
      ref_reg  <= ref_next;
      cfg1_reg <= cfg1_next;
    end
  end

  // done flag
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= done_next;
    end
  end

  // quarter counter of the instruction cycle, free running
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      quarter_reg <= 2'h0;
    end
    else
    begin
      quarter_reg <= quarter_next;
    end
  end

  // state: reset aborts whatever conversion is running
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= adc_seq_pkg::ST_IDLE; // R5
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // bit period divider and period count
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_reg    <= 6'h00;
      period_reg <= 4'h0;
    end
    else
    begin
      div_reg    <= div_next;
      period_reg <= period_next;
    end
  end

  // approximation word
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sar_reg <= '0;
    end
    else
    begin
      sar_reg <= sar_next;
    end
  end

  // result has no reset on purpose: a reset must leave it as it was
  always_ff @(posedge sys_clk_in)
  begin
    if (load_result)
    begin
      result_reg <= sar_reg; // R6 R11 R17
    end
  end

  // trigger pending and the timer clear pulse
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trig_pending_reg <= 1'b0;
      timer_clear_reg  <= 1'b0;
    end
    else
    begin
      trig_pending_reg <= trig_pending_next;
      timer_clear_reg  <= trig_seen; // R2 R3
    end
  end

  // sleep power down and wake pulse
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      off_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      off_reg  <= off_next;
      wake_reg <= wake_next;
    end
  end

  // read data register
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_reg <= adc_seq_pkg::RESET_BYTE;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs
  assign rdata_out             = rdata_reg;
  assign timer_clear_out       = timer_clear_reg;
  assign wake_out              = wake_reg;
  assign irq_out               = done_reg
                                 && enables_reg[adc_seq_pkg::BIT_DONE]
                                 && irq_ctrl_reg[adc_seq_pkg::BIT_PERIPH_IE]
                                 && irq_ctrl_reg[adc_seq_pkg::BIT_GLOBAL_IE]; // R19
  assign converter_enabled_out = power_reg && !off_reg;
  assign sampling_out          = power_reg && !off_reg && !run_flag;
  assign channel_out           = chan_reg;
endmodule : adc_conversion_sequencer
`default_nettype wire

// ==== tb/adc_seq_partner.sv ====
// comparator model: answer flips every cycle so it never holds a stale level
`default_nettype none
module adc_seq_partner (input wire logic c, output logic q);
  timeunit 1ns;
  timeprecision 1ps;
  initial q = 1'b0;
  always @(posedge c) q <= ~q;
endmodule : adc_seq_partner
`default_nettype wire

// ==== tb/adc_seq_assertions.sv ====
// checker for trigger, reset, interrupt, wake and sampling behaviour at the sequencer ports
`default_nettype none
module adc_seq_assertions (
  input wire logic                  sys_clk_in,
  input wire logic                  rst_n_in,
  input wire adc_seq_pkg::bus_req_s bus_in,
  input wire logic [3:0]            compare_mode_in,
  input wire logic                  special_trigger_in,
  input wire logic                  sleep_in,
  input wire logic                  timer_clear_out,
  input wire logic                  wake_out,
  input wire logic                  irq_out,
  input wire logic                  converter_enabled_out,
  input wire logic                  sampling_out
);
  timeunit 1ns;
  timeprecision 1ps;
  a_trig_clears_timer: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    special_trigger_in && (compare_mode_in == adc_seq_pkg::MODE_SPECIAL) |=> timer_clear_out)
    else $error("timer not cleared");
  a_no_stray_clear: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !(special_trigger_in && (compare_mode_in == adc_seq_pkg::MODE_SPECIAL))
    |=> !timer_clear_out)
    else $error("timer cleared without trigger");
  a_reset_quiet: assert property (
    @(posedge sys_clk_in)
    !rst_n_in |-> !irq_out && !converter_enabled_out && !wake_out && !timer_clear_out)
    else $error("outputs active in reset");
  a_irq_sticky: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    irq_out && !bus_in.wr |=> irq_out)
    else $error("interrupt dropped without write");
  a_wake_in_sleep: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wake_out |-> $past(sleep_in))
    else $error("wake outside sleep");
  a_sampling_powered: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    sampling_out |-> converter_enabled_out)
    else $error("sampling while powered down");
  c_irq_raised: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) irq_out);
  c_timer_cleared: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    timer_clear_out);
  c_sampling: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) sampling_out);
endmodule : adc_seq_assertions
bind adc_conversion_sequencer adc_seq_assertions i_adc_seq_assertions (
  .sys_clk_in            (sys_clk_in),
  .rst_n_in              (rst_n_in),
  .bus_in                (bus_in),
  .compare_mode_in       (compare_mode_in),
  .special_trigger_in    (special_trigger_in),
  .sleep_in              (sleep_in),
  .timer_clear_out       (timer_clear_out),
  .wake_out              (wake_out),
  .irq_out               (irq_out),
  .converter_enabled_out (converter_enabled_out),
  .sampling_out          (sampling_out)
);
`default_nettype wire

// ==== tb/test_adc_conversion_sequencer.sv ====
// bench: reset value, software start, done interrupt, trigger
`default_nettype none
module test_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic c = 0, r, t = 0, q, i, tc, e; logic [7:0] d; int n_errors = 0, n_compared = 0;
  adc_seq_pkg::bus_req_s b = '0;
  adc_conversion_sequencer #(.RC_DIV(4)) i_adc_conversion_sequencer (.sys_clk_in(c), .rst_n_in(r),
   .bus_in(b), .rdata_out(d), .compare_mode_in(4'hb), .special_trigger_in(t), .sleep_in(1'b0),
   .comparator_in(q), .timer_clear_out(tc), .wake_out(), .irq_out(i), .converter_enabled_out(e),
   .sampling_out(), .channel_out());
  adc_seq_partner i_adc_seq_partner (.c(c), .q(q));
  task chk(input logic [7:0] g, e); n_compared++;
    if (g !== e) begin n_errors++; $display("[ERR] %0t %h %h", $time, g, e); end endtask : chk
  task io(input logic [7:0] a, w, input logic x);
    @(posedge c) b <= '{a, w, x, ~x}; @(posedge c) b <= '0; #1; endtask : io
  task give_verdict; $display("errors %0d of %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish; endtask : give_verdict
  initial forever #2 c = ~c;
  initial begin #40000; n_errors++; give_verdict; end
  initial begin
    r <= 1'b0;
    repeat (4) @(posedge c); r <= 1;
    io(8'h1f, 8'h0, 0); chk(d, 8'h0);
    chk({7'h0, e}, 8'h0);
    io(8'h8c, 8'h40, 1); io(8'h0b, 8'hc0, 1); io(8'h1f, 8'hc1, 1); io(8'h1f, 8'hc5, 1);
    repeat (200) if (i !== 1'b1) @(posedge c);
    chk({7'h0, i}, 8'h1);
    io(8'h1f, 8'h0, 0); chk(d, 8'hc1);
    io(8'h0c, 8'h0, 0); chk(d, 8'h40);
    io(8'h0c, 8'h40, 1); chk({7'h0, i}, 8'h0);
    io(8'h1f, 8'hc5, 1); repeat (20) @(posedge c); io(8'h1f, 8'hc1, 1);
    io(8'h1f, 8'h0, 0); chk(d, 8'hc1);
    io(8'h9e, 8'h0, 0); chk(d, 8'h0);
    io(8'h1f, 8'h0, 1); @(posedge c) t <= 1; @(posedge c) t <= 0;
    #1 chk({7'h0, tc}, 8'h1);
    io(8'h1f, 8'h0, 0); chk(d, 8'h0);
    repeat (3) @(posedge c); give_verdict;
  end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
